// ===== psm_pkg.sv
package psm_pkg;
  // address widths
  localparam int PSM_EA_W   = 16;
  localparam int PSM_PA_W   = 24;
  localparam int PSM_PAGE_W = 8;
  // field positions
  localparam int PSM_EA_TOP   = 15;
  localparam int PSM_CFG_BIT  = 7;
  localparam int PSM_VIS_EN_B = 2;
  // program counter step per program word
  localparam logic [23:0] PSM_PC_STEP = 24'h00_0002;
  // reset values
  localparam logic [7:0]  PSM_PAGE_RST = 8'h00;
  localparam logic [15:0] PSM_CTRL_RST = 16'h0000;
  localparam logic [23:0] PSM_PC_RST   = 24'h00_0000;
  // implemented configuration-space window, arbitrary bounds
  localparam logic [23:0] PSM_CFG_LO = 24'hFF_0000;
  localparam logic [23:0] PSM_CFG_HI = 24'hFF_0003;

  // request operations: none, table reads and writes, data access
  typedef enum logic [2:0] {
    PSM_OP_NONE  = 3'b000,
    PSM_OP_RDL   = 3'b001,
    PSM_OP_RDH   = 3'b010,
    PSM_OP_WTL   = 3'b011,
    PSM_OP_WTH   = 3'b100,
    PSM_OP_DATA  = 3'b101
  } psm_op_t;
endpackage : psm_pkg

// ===== psm_lane.sv
`timescale 1ns/1ps
// data-lane steering for table reads
module psm_lane (
  // request
  input  wire logic        high_sel,
  input  wire logic        byte_mode,
  input  wire logic        byte_sel,
  // program word
  input  wire logic [23:0] prog_word,
  // result
  output logic      [15:0] rd_data
);
  // pick lanes; the phantom high byte always reads zero
  always_comb begin
    if (!high_sel) begin
      if (!byte_mode) begin
        rd_data = prog_word[15:0];
      end else begin
        rd_data = byte_sel ? {8'h00, prog_word[15:8]}
                           : {8'h00, prog_word[7:0]};
      end
    end else begin
      if (!byte_mode) begin
        rd_data = {8'h00, prog_word[23:16]};
      end else begin
        rd_data = byte_sel ? 16'h0000 : {8'h00, prog_word[23:16]};
      end
    end
  end
endmodule : psm_lane

// ===== psm_mapper.sv
`timescale 1ns/1ps
// Functional notes
// - table address is page over effective address
// - page top bit selects configuration space
// - window address is page over low fifteen
// - window accesses always hit user memory
// - page bit zero forms address bit fifteen
// - program word address LSB held zero
// - table operations accept any byte alignment
// - configuration space: reads only, implemented locations
// - low word read returns low program word
// - low byte read picks byte by select
// - high word read zeroes phantom byte
// - high byte read phantom select returns zero
// - only high table ops touch upper byte
// - program counter steps two per word
// - window is read-only, low word only
// - redirect only when enabled and top bit
module psm_mapper (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // page and control register writes
  input  wire logic        table_page_we,
  input  wire logic [7:0]  table_page_wdata,
  input  wire logic        visibility_page_we,
  input  wire logic [7:0]  visibility_page_wdata,
  input  wire logic        processor_control_we,
  input  wire logic [15:0] processor_control_wdata,
  // processor request
  input  wire logic        req_valid,
  input  wire psm_pkg::psm_op_t req_op,
  input  wire logic        req_write,
  input  wire logic        req_byte_mode,
  input  wire logic [15:0] effective_address,
  input  wire logic [15:0] req_wdata,
  input  wire logic        pc_advance,
  // program memory read data
  input  wire logic [23:0] prog_rdata,
  // program memory request
  output logic             prog_rd,
  output logic             prog_wr_low,
  output logic             prog_wr_high,
  output logic             prog_cfg,
  output logic      [23:0] prog_addr,
  output logic      [15:0] prog_wdata,
  // data memory pass-through
  output logic             data_mem_sel,
  output logic      [15:0] data_mem_addr,
  // results
  output logic             rsp_valid,
  output logic      [15:0] rsp_data,
  output logic             rsp_refused,
  // register views
  output logic      [7:0]  table_page_reg,
  output logic      [7:0]  visibility_page_reg,
  output logic      [15:0] processor_control_reg,
  output logic      [23:0] pc
);

  // whole module state
  typedef struct packed {
    logic [7:0]  tpage;
    logic [7:0]  vpage;
    logic [15:0] ctrl;
    logic [23:0] pc;
    logic        p_rd;
    logic        p_wl;
    logic        p_wh;
    logic        p_cfg;
    logic [23:0] p_addr;
    logic [15:0] p_wdata;
    logic        d_sel;
    logic [15:0] d_addr;
    logic        pend;
    logic        pend_high;
    logic        pend_byte;
    logic        pend_bsel;
    logic        rsp_v;
    logic [15:0] rsp_d;
    logic        refused;
  } psm_state_t;

  psm_state_t st_r;
  psm_state_t st_nxt;
  logic [15:0] lane_data;

  // table address: page above full effective address, lsb cleared for the word
  function automatic logic [23:0] psm_table_addr(input logic [7:0] pg,
                                                  input logic [15:0] ea);
    psm_table_addr = {pg, ea[15:1], 1'b0};
  endfunction : psm_table_addr

  // window address: bit 23 forced low, ea top bit dropped
  function automatic logic [23:0] psm_window_addr(input logic [7:0] pg,
                                                   input logic [15:0] ea);
    psm_window_addr = {1'b0, pg, ea[14:1], 1'b0};
  endfunction : psm_window_addr

  // implemented configuration locations
  function automatic logic psm_cfg_ok(input logic [23:0] a);
    psm_cfg_ok = (a >= psm_pkg::PSM_CFG_LO) && (a <= psm_pkg::PSM_CFG_HI);
  endfunction : psm_cfg_ok

  // lane steering on the returned program word
  psm_lane u_lane (
    .high_sel  (st_r.pend_high),
    .byte_mode (st_r.pend_byte),
    .byte_sel  (st_r.pend_bsel),
    .prog_word (prog_rdata),
    .rd_data   (lane_data)
  );

  // next state
  always_comb begin
    logic        cfg;
    logic        vis;
    logic [23:0] ta;
    cfg = 1'b0;
    vis = 1'b0;
    ta  = '0;
    st_nxt = st_r;
    st_nxt.p_rd    = 1'b0;
    st_nxt.p_wl    = 1'b0;
    st_nxt.p_wh    = 1'b0;
    st_nxt.d_sel   = 1'b0;
    st_nxt.rsp_v   = 1'b0;
    st_nxt.refused = 1'b0;
    st_nxt.pend    = 1'b0;
    if (table_page_we) st_nxt.tpage = table_page_wdata;
    if (visibility_page_we) st_nxt.vpage = visibility_page_wdata;
    if (processor_control_we) st_nxt.ctrl = processor_control_wdata;
    // pc steps two so program words line up with data words
    if (pc_advance) st_nxt.pc = st_r.pc + psm_pkg::PSM_PC_STEP;
    // read data returns one cycle after the memory request
    if (st_r.pend) begin
      st_nxt.rsp_v = 1'b1;
      st_nxt.rsp_d = lane_data;
    end
    if (req_valid) begin
      unique case (req_op)
        psm_pkg::PSM_OP_RDL, psm_pkg::PSM_OP_RDH,
        psm_pkg::PSM_OP_WTL, psm_pkg::PSM_OP_WTH: begin
          // any byte alignment accepted; byte select is ea bit 0
          ta  = psm_table_addr(st_r.tpage, effective_address);
          cfg = st_r.tpage[psm_pkg::PSM_CFG_BIT];
          st_nxt.p_addr  = ta;
          st_nxt.p_cfg   = cfg;
          st_nxt.p_wdata = req_wdata;
          if (req_op == psm_pkg::PSM_OP_RDL || req_op == psm_pkg::PSM_OP_RDH) begin
            // config reads only at implemented locations
            if (cfg && !psm_cfg_ok(ta)) begin
              st_nxt.refused = 1'b1;
            end else begin
              st_nxt.p_rd      = 1'b1;
              st_nxt.pend      = 1'b1;
              st_nxt.pend_high = (req_op == psm_pkg::PSM_OP_RDH);
              st_nxt.pend_byte = req_byte_mode;
              st_nxt.pend_bsel = effective_address[0];
            end
          end else if (cfg) begin
            st_nxt.refused = 1'b1;
          end else begin
            st_nxt.p_wl = (req_op == psm_pkg::PSM_OP_WTL);
            st_nxt.p_wh = (req_op == psm_pkg::PSM_OP_WTH);
          end
        end
        psm_pkg::PSM_OP_DATA: begin
          vis = st_r.ctrl[psm_pkg::PSM_VIS_EN_B]
                && effective_address[psm_pkg::PSM_EA_TOP];
          if (vis && req_write) begin
            st_nxt.refused = 1'b1;
          end else if (vis) begin
            st_nxt.p_addr    = psm_window_addr(st_r.vpage, effective_address);
            st_nxt.p_cfg     = 1'b0;
            st_nxt.p_rd      = 1'b1;
            st_nxt.pend      = 1'b1;
            st_nxt.pend_high = 1'b0;
            st_nxt.pend_byte = 1'b0;
            st_nxt.pend_bsel = 1'b0;
          end else begin
            st_nxt.d_sel  = 1'b1;
            st_nxt.d_addr = effective_address;
          end
        end
        default: begin
          st_nxt.refused = 1'b0;
        end
      endcase
    end
  end

  // single state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r       <= '0;
      st_r.tpage <= psm_pkg::PSM_PAGE_RST;
      st_r.vpage <= psm_pkg::PSM_PAGE_RST;
      st_r.ctrl  <= psm_pkg::PSM_CTRL_RST;
      st_r.pc    <= psm_pkg::PSM_PC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  assign prog_rd               = st_r.p_rd;
  assign prog_wr_low           = st_r.p_wl;
  assign prog_wr_high          = st_r.p_wh;
  assign prog_cfg              = st_r.p_cfg;
  assign prog_addr             = st_r.p_addr;
  assign prog_wdata            = st_r.p_wdata;
  assign data_mem_sel          = st_r.d_sel;
  assign data_mem_addr         = st_r.d_addr;
  assign rsp_valid             = st_r.rsp_v;
  assign rsp_data              = st_r.rsp_d;
  assign rsp_refused           = st_r.refused;
  assign table_page_reg        = st_r.tpage;
  assign visibility_page_reg   = st_r.vpage;
  assign processor_control_reg = st_r.ctrl;
  assign pc                    = st_r.pc;

  // assertions
  property p_addr_lsb;
    @(posedge sys_clk) disable iff (!rst_n)
      (prog_rd || prog_wr_low || prog_wr_high) |-> (prog_addr[0] == 1'b0);
  endproperty
  a_addr_lsb: assert property (p_addr_lsb) else $error("program address lsb set");

  property p_tbl_addr;
    @(posedge sys_clk) disable iff (!rst_n)
      (req_valid && req_op == psm_pkg::PSM_OP_RDL && !table_page_we
       && !table_page_reg[psm_pkg::PSM_CFG_BIT])
      |=> (prog_addr == {$past(table_page_reg), $past(effective_address[15:1]), 1'b0});
  endproperty
  a_tbl_addr: assert property (p_tbl_addr) else $error("table address wrong");

  property p_cfg_sel;
    @(posedge sys_clk) disable iff (!rst_n)
      (req_valid && req_op == psm_pkg::PSM_OP_RDH)
      |=> (prog_rd |-> prog_cfg == $past(table_page_reg[psm_pkg::PSM_CFG_BIT]));
  endproperty
  a_cfg_sel: assert property (p_cfg_sel) else $error("config select wrong");

  property p_win_addr;
    @(posedge sys_clk) disable iff (!rst_n)
      (req_valid && req_op == psm_pkg::PSM_OP_DATA && !req_write
       && processor_control_reg[psm_pkg::PSM_VIS_EN_B]
       && effective_address[psm_pkg::PSM_EA_TOP])
      |=> (prog_rd && !prog_cfg && prog_addr[23] == 1'b0
           && prog_addr[15] == $past(visibility_page_reg[0]));
  endproperty
  a_win_addr: assert property (p_win_addr) else $error("window address wrong");

  property p_no_redirect;
    @(posedge sys_clk) disable iff (!rst_n)
      (req_valid && req_op == psm_pkg::PSM_OP_DATA
       && !(processor_control_reg[psm_pkg::PSM_VIS_EN_B]
            && effective_address[psm_pkg::PSM_EA_TOP]))
      |=> (data_mem_sel && !prog_rd);
  endproperty
  a_no_redirect: assert property (p_no_redirect) else $error("data access redirected");

  property p_cfg_nowrite;
    @(posedge sys_clk) disable iff (!rst_n)
      (prog_wr_low || prog_wr_high) |-> !prog_cfg;
  endproperty
  a_cfg_nowrite: assert property (p_cfg_nowrite) else $error("config write issued");

  property p_rsp_timing;
    @(posedge sys_clk) disable iff (!rst_n)
      prog_rd |=> rsp_valid;
  endproperty
  a_rsp_timing: assert property (p_rsp_timing) else $error("read answer late");

  property p_win_ro;
    @(posedge sys_clk) disable iff (!rst_n)
      (req_valid && req_op == psm_pkg::PSM_OP_DATA && req_write
       && processor_control_reg[psm_pkg::PSM_VIS_EN_B]
       && effective_address[psm_pkg::PSM_EA_TOP])
      |=> (rsp_refused && !prog_wr_low && !prog_wr_high);
  endproperty
  a_win_ro: assert property (p_win_ro) else $error("window write not refused");

  property p_pc_step;
    @(posedge sys_clk) disable iff (!rst_n)
      pc_advance |=> (pc == $past(pc) + psm_pkg::PSM_PC_STEP);
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc step not two");

endmodule : psm_mapper

// ===== psm_mem_model.sv
`timescale 1ns/1ps
// program memory stand-in, answers in the cycle the read strobe stands
module psm_mem_model (
  // clock
  input  wire logic        sys_clk,
  // read request
  input  wire logic        prog_rd,
  input  wire logic [23:0] prog_addr,
  // read data
  output logic      [23:0] prog_rdata
);
  logic [23:0] held_r = 24'h00_0000;
  // contents scramble the address, so a wrong address shows up
  function automatic logic [23:0] word_at(input logic [23:0] a);
    return {a[23:16] ^ a[7:0], a[15:0] ^ 16'h3C5A};
  endfunction : word_at
  // outside a read the bus toggles, so stale data never matches by luck
  always_ff @(posedge sys_clk) begin
    held_r <= prog_rd ? word_at(prog_addr) : ~held_r;
  end
  assign prog_rdata = prog_rd ? word_at(prog_addr) : held_r;
endmodule : psm_mem_model

// ===== psm_mapper_bench.sv
`timescale 1ns/1ps
module psm_mapper_bench;
  logic sys_clk = 1'b0, rst_n = 1'b0;
  logic tp_we = 1'b0, vp_we = 1'b0, ct_we = 1'b0, req_valid = 1'b0;
  logic req_write = 1'b0, req_bm = 1'b0, pc_adv = 1'b0;
  logic [7:0] tp_wd = 8'h00, vp_wd = 8'h00, tp = 8'h00, vp = 8'h00;
  logic [15:0] ct_wd = 16'h0000, ea = 16'h0000, wd = 16'h0000, ct = 16'h0000;
  psm_pkg::psm_op_t op = psm_pkg::PSM_OP_NONE;
  logic [23:0] prdata, paddr, pc_v, pc_exp;
  logic prd, pwl, pwh, pcfg, dsel, rv, rref;
  logic [15:0] pwd, daddr, rdat, ctv;
  logic [7:0] tpv, vpv;
  int errors = 0, checks = 0;

  always #10 sys_clk = ~sys_clk;

  psm_mapper u_psm_mapper (.sys_clk(sys_clk), .rst_n(rst_n), .table_page_we(tp_we),
    .table_page_wdata(tp_wd), .visibility_page_we(vp_we), .visibility_page_wdata(vp_wd),
    .processor_control_we(ct_we), .processor_control_wdata(ct_wd), .req_valid(req_valid),
    .req_op(op), .req_write(req_write), .req_byte_mode(req_bm), .effective_address(ea),
    .req_wdata(wd), .pc_advance(pc_adv), .prog_rdata(prdata), .prog_rd(prd),
    .prog_wr_low(pwl), .prog_wr_high(pwh), .prog_cfg(pcfg), .prog_addr(paddr),
    .prog_wdata(pwd), .data_mem_sel(dsel), .data_mem_addr(daddr), .rsp_valid(rv),
    .rsp_data(rdat), .rsp_refused(rref), .table_page_reg(tpv), .visibility_page_reg(vpv),
    .processor_control_reg(ctv), .pc(pc_v));
  psm_mem_model u_psm_mem_model (.sys_clk(sys_clk), .prog_rd(prd), .prog_addr(paddr),
    .prog_rdata(prdata));

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic test_done;
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // own copy of the memory scramble
  function automatic logic [23:0] exp_word(input logic [23:0] a);
    return {a[23:16] ^ a[7:0], a[15:0] ^ 16'h3C5A};
  endfunction : exp_word

  // page and control writes, views checked a cycle later
  task automatic set_regs(input logic [7:0] t, input logic [7:0] v, input logic [15:0] c);
    @(posedge sys_clk);
    {tp_we, vp_we, ct_we} <= 3'b111;
    {tp_wd, vp_wd, ct_wd} <= {t, v, c};
    @(posedge sys_clk);
    {tp_we, vp_we, ct_we} <= 3'b000;
    {tp, vp, ct} = {t, v, c};
    #1;
    chk("table_page", {16'h0000, t}, {16'h0000, tpv});
    chk("vis_page", {16'h0000, v}, {16'h0000, vpv});
    chk("control", {8'h00, c}, {8'h00, ctv});
  endtask : set_regs

  // one request, expectations worked out from the mapping rules
  task automatic run(input psm_pkg::psm_op_t o, input logic [15:0] e, input logic bm,
                     input logic w);
    logic tbl, win, rd, rf;
    logic [23:0] a, p;
    logic [15:0] d;
    tbl = o inside {psm_pkg::PSM_OP_RDL, psm_pkg::PSM_OP_RDH,
                    psm_pkg::PSM_OP_WTL, psm_pkg::PSM_OP_WTH};
    win = (o == psm_pkg::PSM_OP_DATA) && ct[2] && e[15];
    a = tbl ? {tp, e[15:1], 1'b0} : {1'b0, vp, e[14:1], 1'b0};
    rd = o == psm_pkg::PSM_OP_RDL || o == psm_pkg::PSM_OP_RDH || (win && !w);
    rf = (tbl && tp[7] && (!rd || a > psm_pkg::PSM_CFG_HI || a < psm_pkg::PSM_CFG_LO))
         || (win && w);
    @(posedge sys_clk);
    {req_valid, req_bm, req_write} <= {1'b1, bm, w};
    {op, ea} <= {o, e};
    wd <= e ^ 16'h5A5A;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    #1;
    // answer comes two cycles after the request, never one
    chk("rsp_idle", 24'h00_0000, {23'd0, rv});
    chk("refused", {23'd0, rf}, {23'd0, rref});
    chk("prog_rd", {23'd0, rd && !rf}, {23'd0, prd});
    chk("wr_low", {23'd0, o == psm_pkg::PSM_OP_WTL && !rf}, {23'd0, pwl});
    chk("wr_high", {23'd0, o == psm_pkg::PSM_OP_WTH && !rf}, {23'd0, pwh});
    chk("data_sel", {23'd0, o == psm_pkg::PSM_OP_DATA && !win}, {23'd0, dsel});
    if (o == psm_pkg::PSM_OP_DATA && !win) chk("data_addr", {8'h00, e}, {8'h00, daddr});
    if ((tbl || win) && !rf) begin
      chk("prog_addr", a, paddr);
      chk("prog_cfg", {23'd0, tbl && tp[7]}, {23'd0, pcfg});
    end
    if (tbl && !rd && !rf) chk("prog_wdata", {8'h00, e ^ 16'h5A5A}, {8'h00, pwd});
    if (rd && !rf) begin
      p = exp_word(a);
      if (win) d = p[15:0];
      else if (o == psm_pkg::PSM_OP_RDL) d = bm ? {8'h00, e[0] ? p[15:8] : p[7:0]} : p[15:0];
      else d = (bm && e[0]) ? 16'h0000 : {8'h00, p[23:16]};
      @(posedge sys_clk);
      #1;
      chk("rsp_valid", 24'h00_0001, {23'd0, rv});
      chk("rd_pulse", 24'h00_0000, {23'd0, prd});
      if (bm && !win) chk("rsp_low", {16'h0000, d[7:0]}, {16'h0000, rdat[7:0]});
      else chk("rsp_data", {8'h00, d}, {8'h00, rdat});
    end
  endtask : run

  task automatic step_pc;
    @(posedge sys_clk);
    pc_adv <= 1'b1;
    @(posedge sys_clk);
    pc_adv <= 1'b0;
    #1;
    pc_exp = pc_exp + 24'h00_0002;
    chk("pc", pc_exp, pc_v);
  endtask : step_pc

  initial begin
    void'($urandom(21954));
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk("pc_reset", 24'h00_0000, pc_v);
    pc_exp = 24'h00_0000;
    // every table op, word and both byte selects, user page
    set_regs(8'h12, 8'h81, 16'h0004);
    for (int i = 0; i < 12; i++)
      run(psm_pkg::psm_op_t'(3'(i / 3 + 1)), 16'hF3A4 | 16'(i % 2), 1'(i % 3 > 0), 1'b0);
    // configuration page: reads inside, reads outside, writes refused
    set_regs(8'hFF, 8'hFF, 16'h0004);
    for (int i = 0; i < 4; i++) run(psm_pkg::PSM_OP_RDL, 16'(i), 1'b0, 1'b0);
    run(psm_pkg::PSM_OP_RDH, 16'h0003, 1'b0, 1'b0);
    run(psm_pkg::PSM_OP_RDL, 16'h0004, 1'b0, 1'b0);
    run(psm_pkg::PSM_OP_WTL, 16'h0000, 1'b0, 1'b0);
    run(psm_pkg::PSM_OP_WTH, 16'h0002, 1'b1, 1'b0);
    // window read, window write, window disabled, low half of data space
    run(psm_pkg::PSM_OP_DATA, 16'hFFFF, 1'b0, 1'b0);
    run(psm_pkg::PSM_OP_DATA, 16'h8000, 1'b0, 1'b1);
    set_regs(8'h01, 8'h7E, 16'hFFFB);
    run(psm_pkg::PSM_OP_DATA, 16'hC002, 1'b0, 1'b0);
    run(psm_pkg::PSM_OP_DATA, 16'h7FFE, 1'b0, 1'b1);
    step_pc();
    step_pc();
    // a request with no operation must touch neither memory
    run(psm_pkg::PSM_OP_NONE, 16'hFFFF, 1'b0, 1'b1);
    // reset in mid-run clears pages, control, pc and the read, answer and refusal pulses
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("rst_pages", 24'h00_0000, {8'h00, tpv, vpv});
    chk("rst_ctrl", 24'h00_0000, {8'h00, ctv});
    chk("rst_pc", 24'h00_0000, pc_v);
    chk("rst_pulses", 24'h00_0000, {21'd0, prd, rv, rref});
    @(posedge sys_clk);
    rst_n <= 1'b1;
    {tp, vp, ct} = 32'h0000_0000;
    pc_exp = 24'h00_0000;
    // first request right after release, on the cleared page
    run(psm_pkg::PSM_OP_RDL, 16'h1235, 1'b1, 1'b0);
    // random mix
    for (int i = 0; i < 300; i++) begin
      if (i % 25 == 0) set_regs(8'($urandom), 8'($urandom), 16'($urandom));
      run(psm_pkg::psm_op_t'(3'($urandom_range(1, 5))), 16'($urandom), 1'($urandom),
          1'($urandom));
      if (i % 40 == 0) step_pc();
    end
    test_done();
  end
endmodule : psm_mapper_bench
